// ==== logic/odt_defines.vh ====
// Constants for the termination timing-mode block: times, counts, states.
// Assumes one 25 MHz clock and inclusion by bare name.
`ifndef ODT_DEFINES_VH
`define ODT_DEFINES_VH

// Clock period in picoseconds
`define ODT_CLK_PS 40000
// Asynchronous turn-on / turn-off delays, picoseconds
`define ODT_AONPD_MIN_PS 2000
`define ODT_AONPD_MAX_PS 8500
`define ODT_AOFPD_MIN_PS 2000
`define ODT_AOFPD_MAX_PS 8500

// Command-path-disable and locked power-down exit intervals, cycles
`define ODT_CPDED_CYC 5'h01
`define ODT_XPDLL_CYC 5'h0A

// Latency history depth and widths
`define ODT_HIST_W 32
`define ODT_LAT_W 6
`define ODT_CNT_W 5

// Timing-mode states
`define ODT_ST_SYNC 3'h0
`define ODT_ST_ENTRY 3'h1
`define ODT_ST_ASYNC 3'h2
`define ODT_ST_EXIT 3'h3
`define ODT_ST_PD_SYNC 3'h4

// Reset values
`define ODT_RST_STATE 3'h0
`define ODT_RST_CNT 5'h00
`define ODT_RST_LAST 6'h3F
`endif

// ==== logic/odt_async_ctrl.v ====
// Termination timing-mode control: synchronous or asynchronous RTT response.
// Assumes all inputs are synchronous to clock (the controller's CK).
//
// Notes on behaviour
// - Async timing when DLL frozen in powerdown
// - Async path skips additive latency
// - Async turn-on between 2 and 8.5 ns; rtt_on here rises one 40 ns clock after ODT is sampled
// - Async turn-off between 2 and 8.5 ns; rtt_on here falls one 40 ns clock after ODT is sampled
// - ODT receiver stays on in powerdown
// - Entry window starts WL-1 before CKE low
// - Entry window ends after command-path-disable interval
// - Pending refresh extends the entry window
// - Window start included, end included
// - Rise in window lands between both delays
// - Fall in window lands between both delays
// - Exit window WL-1 before to XPDLL after
// - Entry window: synchronous before, asynchronous after; exit window the reverse
// - Short powerdown merges entry and exit windows
// - Short idle merges exit and entry windows
// - Synchronous latency is WL minus two
`include "odt_defines.vh"

module odt_async_ctrl (
   input wire clock,
   input wire nrst,
   input wire cke,
   input wire odt,
   input wire cmd_rdwr,
   input wire refresh_busy,
   input wire mr0_pd_dll_fast,
   input wire dll_enable,
   input wire [3:0] cwl,
   input wire [4:0] al,
   output reg rtt_on,
   output reg async_mode,
   output reg trans_window,
   output reg change_uncertain,
   output reg rdwr_in_pd,
   output wire cmd_rx_enable,
   output wire odt_rx_enable
);

   ////////////////////////////////////////////////////////////////////////
   // Derived cycle counts

   // Least time rounds up, longest rounds down, never below one cycle
   localparam integer AON_MIN_RAW =
      (`ODT_AONPD_MIN_PS + `ODT_CLK_PS - 1) / `ODT_CLK_PS;
   localparam integer AON_MAX_RAW = `ODT_AONPD_MAX_PS / `ODT_CLK_PS;
   localparam integer AOF_MIN_RAW =
      (`ODT_AOFPD_MIN_PS + `ODT_CLK_PS - 1) / `ODT_CLK_PS;
   localparam integer AOF_MAX_RAW = `ODT_AOFPD_MAX_PS / `ODT_CLK_PS;
   localparam integer AON_MIN_CYC = (AON_MIN_RAW < 1) ? 1 : AON_MIN_RAW;
   localparam integer AON_MAX_CYC = (AON_MAX_RAW < 1) ? 1 : AON_MAX_RAW;
   localparam integer AOF_MIN_CYC = (AOF_MIN_RAW < 1) ? 1 : AOF_MIN_RAW;
   localparam integer AOF_MAX_CYC = (AOF_MAX_RAW < 1) ? 1 : AOF_MAX_RAW;
   // Async tap: the earliest legal cycle, with the turn-on minimum capped at its maximum
   localparam integer ASYNC_CYC =
      (AON_MIN_CYC > AON_MAX_CYC) ? AON_MAX_CYC : AON_MIN_CYC;
   localparam integer ASYNC_TAP =
      (AOF_MIN_CYC > ASYNC_CYC) ? AOF_MIN_CYC - 1 : ASYNC_CYC - 1;

   ////////////////////////////////////////////////////////////////////////
   // Latencies

   wire [`ODT_LAT_W-1:0] wl;
   wire [`ODT_LAT_W-1:0] odtl;
   wire [`ODT_LAT_W-1:0] sync_tap;
   wire [`ODT_LAT_W-1:0] anpd;

   // Write latency includes AL; the async path never sees it
   assign wl = {2'h0, cwl} + {1'h0, al};
   assign odtl = (wl > 6'h02) ? wl - 6'h02 : 6'h01;
   assign sync_tap = odtl - 6'h01;
   assign anpd = (wl > 6'h01) ? wl - 6'h01 : 6'h00;

   ////////////////////////////////////////////////////////////////////////
   // ODT history, one flop per cycle of latency

   wire [`ODT_HIST_W-1:0] hist;
   reg odt_q;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         odt_q <= 1'b0;
      end else begin
         odt_q <= odt;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `ODT_HIST_W; gi = gi + 1) begin : g_hist
         reg stage;
         // Head flop samples the pin; the rest shift once per cycle
         if (gi == 0) begin : g_head
            always @(posedge clock or negedge nrst) begin
               if (!nrst) begin
                  stage <= 1'b0;
               end else begin
                  stage <= odt;
               end
            end
         end else begin : g_tail
            always @(posedge clock or negedge nrst) begin
               if (!nrst) begin
                  stage <= 1'b0;
               end else begin
                  stage <= hist[gi-1];
               end
            end
         end
         assign hist[gi] = stage;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Cycles since the last ODT level change, saturating

   reg [`ODT_LAT_W-1:0] since_chg;
   wire odt_chg;

   assign odt_chg = odt ^ odt_q;

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         since_chg <= `ODT_RST_LAST;
      end else if (odt_chg) begin
         since_chg <= 6'h00;
      end else if (since_chg != `ODT_RST_LAST) begin
         since_chg <= since_chg + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timing-mode state machine

   reg cke_q;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [`ODT_CNT_W-1:0] cnt;
   reg [`ODT_CNT_W-1:0] next_cnt;
   wire cke_fall;
   wire cke_rise;
   wire frozen;

   assign cke_fall = cke_q & ~cke;
   assign cke_rise = ~cke_q & cke;
   // DLL-on part whose DLL is frozen in precharge powerdown
   assign frozen = dll_enable & ~mr0_pd_dll_fast;

   always @* begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         `ODT_ST_SYNC: begin
            if (cke_fall) begin
               next_state = frozen ? `ODT_ST_ENTRY : `ODT_ST_PD_SYNC;
               next_cnt = 5'h01;
            end
         end
         `ODT_ST_ENTRY: begin
            if (cke_rise) begin
               next_state = `ODT_ST_EXIT;
               next_cnt = 5'h01;
            end else if (cnt <= `ODT_CPDED_CYC) begin
               next_cnt = cnt + 5'h01;
            end else if (!refresh_busy) begin
               next_state = `ODT_ST_ASYNC;
            end
         end
         `ODT_ST_ASYNC: begin
            if (cke_rise) begin
               next_state = `ODT_ST_EXIT;
               next_cnt = 5'h01;
            end
         end
         `ODT_ST_EXIT: begin
            if (cke_fall) begin
               next_state = `ODT_ST_ENTRY;
               next_cnt = 5'h01;
            end else if (cnt <= `ODT_XPDLL_CYC) begin
               next_cnt = cnt + 5'h01;
            end else begin
               next_state = `ODT_ST_SYNC;
            end
         end
         `ODT_ST_PD_SYNC: begin
            if (cke_rise) begin
               next_state = `ODT_ST_SYNC;
            end
         end
         default: begin
            next_state = `ODT_ST_SYNC;
            next_cnt = `ODT_RST_CNT;
         end
      endcase
   end

   // Idle CKE level at reset, so release shows no false fall
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cke_q <= 1'b1;
      end else begin
         cke_q <= cke;
      end
   end

   // State and window counter registers
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= `ODT_RST_STATE;
      end else begin
         state <= next_state;
      end
   end

   // Window counter; the state machine bounds it
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt <= `ODT_RST_CNT;
      end else begin
         cnt <= next_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Termination output and flags

   wire in_window;
   wire use_async;
   wire late_chg;
   wire next_rtt;
   wire async_level;
   wire sync_level;
   wire in_pd;

   assign in_window = (state == `ODT_ST_ENTRY) || (state == `ODT_ST_EXIT);
   // Windows use the async tap, the later of both minimum delays
   assign use_async = in_window || (state == `ODT_ST_ASYNC);
   // A change WL-1 or fewer cycles before the CKE edge (WL-1 included, edge cycle excluded) is uncertain
   assign late_chg = frozen && (cke_fall || cke_rise) &&
      (since_chg < anpd) && (state != `ODT_ST_PD_SYNC);
   // Async path takes the raw sampled level, no AL
   assign async_level = hist[ASYNC_TAP];
   assign sync_level = hist[sync_tap[4:0]];
   assign next_rtt = use_async ? async_level : sync_level;
   assign in_pd = (state == `ODT_ST_ENTRY) || (state == `ODT_ST_ASYNC) ||
      (state == `ODT_ST_PD_SYNC);

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rtt_on <= 1'b0;
      end else begin
         rtt_on <= next_rtt;
      end
   end

   // Settled async state only; windows report separately
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         async_mode <= 1'b0;
      end else begin
         async_mode <= (next_state == `ODT_ST_ASYNC);
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         trans_window <= 1'b0;
      end else begin
         trans_window <= (next_state == `ODT_ST_ENTRY) ||
            (next_state == `ODT_ST_EXIT);
      end
   end

   // One-cycle pulse: a change inside a window or just before one
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         change_uncertain <= 1'b0;
      end else begin
         change_uncertain <= late_chg || (in_window && odt_chg);
      end
   end

   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdwr_in_pd <= 1'b0;
      end else begin
         // Controller is not meant to do this; flag it, ignore it
         rdwr_in_pd <= in_pd & cmd_rdwr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receiver enables

   // Command receivers may sleep in powerdown; ODT receiver never does
   assign cmd_rx_enable = ~in_pd;
   assign odt_rx_enable = 1'b1;

endmodule // odt_async_ctrl

// ==== sim/oac_chk_sva.sv ====
// Port-level checker for the termination timing-mode block.
// Assumes one clock and the active-low asynchronous reset nrst.
module oac_chk (
   input wire clock,
   input wire nrst,
   input wire cke,
   input wire odt,
   input wire cmd_rdwr,
   input wire refresh_busy,
   input wire mr0_pd_dll_fast,
   input wire dll_enable,
   input wire [3:0] cwl,
   input wire [4:0] al,
   input wire rtt_on,
   input wire async_mode,
   input wire trans_window,
   input wire change_uncertain,
   input wire rdwr_in_pd,
   input wire cmd_rx_enable,
   input wire odt_rx_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge clock); endclocking
   default disable iff (!nrst);
   wire fz = !mr0_pd_dll_fast && dll_enable;
   rx_kept_a: assert property (odt_rx_enable)
      else $error("odt receiver off");
   cmd_off_a: assert property (async_mode |-> !cmd_rx_enable)
      else $error("command receiver on in powerdown");
   rdwr_flag_a: assert property (async_mode && !cke && cmd_rdwr
      |-> ##[1:2] rdwr_in_pd) else $error("read/write not flagged");
   entry_open_a: assert property (fz && $fell(cke) |=> trans_window)
      else $error("entry window not open");
   entry_end_a: assert property (fz && !refresh_busy && $fell(cke)
      ##1 !cke[*2] |=> async_mode && !trans_window) else $error("entry end");
   refr_hold_a: assert property (trans_window && refresh_busy && !cke
      |=> trans_window) else $error("window closed during refresh");
   exit_open_a: assert property (async_mode && $rose(cke)
      |=> trans_window && !async_mode) else $error("exit window not open");
   async_on_a: assert property (async_mode && !cke && $rose(odt)
      |-> ##[1:2] rtt_on) else $error("async turn-on late");
   async_off_a: assert property (async_mode && !cke && $fell(odt)
      |-> ##[1:2] !rtt_on) else $error("async turn-off late");
   win_unc_a: assert property (trans_window && $changed(odt)
      |-> ##[1:2] change_uncertain) else $error("uncertain change missed");
   no_freeze_a: assert property (!fz |-> !async_mode)
      else $error("async without frozen DLL");
   sync_lat_a: assert property (cke && !trans_window && !async_mode
      && al == 5'h00 && cwl == 4'h5 && $rose(odt)
      |=> !rtt_on ##1 !rtt_on ##[1:2] rtt_on) else $error("sync latency");
   cover property (fz && $fell(cke));
   cover property (async_mode && $rose(odt));
   cover property (change_uncertain);
endmodule // oac_chk
bind odt_async_ctrl oac_chk u_chk (.*);

// ==== sim/oac_ctl_model.sv ====
// Controller model: drives CKE, ODT and read/write requests.
// Assumes at most one drive call per clock cycle.
module oac_ctl_model (
   input wire clock,
   output logic cke,
   output logic odt,
   output logic cmd_rdwr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cke = 1'h1;
      odt = 1'h0;
      cmd_rdwr = 1'h0;
   end
   // Read/write in powerdown only when a scenario asks for a refusal
   task drive(input logic c, input logic o, input logic r);
      @(posedge clock);
      cke <= c;
      odt <= o;
      cmd_rdwr <= r;
   endtask
endmodule // oac_ctl_model

// ==== sim/testbench.sv ====
// Self-checking bench for the termination timing-mode block.
// Assumes the controller model drives cke, odt and cmd_rdwr.
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
   error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'h0, nrst = 1'h0, refresh_busy = 1'h0;
   logic mr0_pd_dll_fast = 1'h0, dll_enable = 1'h1;
   logic [3:0] cwl = 4'h5;
   logic [4:0] al = 5'h00;
   wire cke, odt, cmd_rdwr, rtt_on, async_mode, trans_window;
   wire change_uncertain, rdwr_in_pd, cmd_rx_enable, odt_rx_enable;
   logic unc_seen = 1'h0, rd_seen = 1'h0;
   int error_cnt = 0, checks_done = 0;
   initial forever #20 clock = ~clock;
   oac_ctl_model ctl (.*);
   odt_async_ctrl dut (.*);
   // Pulses are made sticky so a check may look a cycle later
   always @(posedge clock) begin
      if (change_uncertain === 1'h1) unc_seen <= 1'h1;
      if (rdwr_in_pd === 1'h1) rd_seen <= 1'h1;
   end
   ////////////////////////////////////////
   task w(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task tally_and_finish;
      if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task t_sync;
      ctl.drive(1'h1, 1'h1, 1'h0);
      w(2);
      `CHK("sync_on_early", 1'h0, rtt_on)
      w(4);
      `CHK("sync_on", 1'h1, rtt_on)
      ctl.drive(1'h1, 1'h0, 1'h0);
      w(2);
      `CHK("sync_off_early", 1'h1, rtt_on)
      w(4);
      `CHK("sync_off", 1'h0, rtt_on)
   endtask
   task t_pd;
      @(posedge clock) al <= 5'h0A;
      ctl.drive(1'h0, 1'h0, 1'h0);
      w(1);
      `CHK("entry_win", 1'h1, trans_window)
      w(1);
      `CHK("entry_end", 1'h1, trans_window)
      `CHK("entry_unc", 1'h1, unc_seen)
      w(1);
      `CHK("async", 1'h1, async_mode)
      `CHK("cmd_rx", 1'h0, cmd_rx_enable)
      ctl.drive(1'h0, 1'h1, 1'h1);
      w(3);
      `CHK("async_on", 1'h1, rtt_on)
      `CHK("rdwr_flag", 1'h1, rd_seen)
      ctl.drive(1'h0, 1'h0, 1'h0);
      w(2);
      `CHK("async_off", 1'h0, rtt_on)
      @(posedge clock) unc_seen <= 1'h0;
      ctl.drive(1'h1, 1'h0, 1'h0);
      w(1);
      `CHK("exit_win", 1'h1, trans_window)
      w(1);
      `CHK("exit_unc", 1'h1, unc_seen)
      w(13);
      `CHK("exit_end", 1'h0, trans_window)
      `CHK("exit_cmd_rx", 1'h1, cmd_rx_enable)
      @(posedge clock) al <= 5'h00;
   endtask
   task t_refresh;
      @(posedge clock) refresh_busy <= 1'h1;
      ctl.drive(1'h0, 1'h0, 1'h0);
      w(5);
      `CHK("refr_win", 1'h1, trans_window)
      @(posedge clock) refresh_busy <= 1'h0;
      w(3);
      `CHK("refr_end", 1'h1, async_mode)
      ctl.drive(1'h1, 1'h0, 1'h0);
      w(14);
   endtask
   task t_fast;
      @(posedge clock) mr0_pd_dll_fast <= 1'h1;
      ctl.drive(1'h0, 1'h0, 1'h0);
      w(4);
      `CHK("fast_pd", 1'h0, async_mode)
      `CHK("fast_rx", 1'h0, cmd_rx_enable)
      ctl.drive(1'h1, 1'h0, 1'h0);
      w(14);
      @(posedge clock) mr0_pd_dll_fast <= 1'h0;
      @(posedge clock) dll_enable <= 1'h0;
      ctl.drive(1'h0, 1'h0, 1'h0);
      w(4);
      `CHK("dll_off_pd", 1'h0, async_mode)
      ctl.drive(1'h1, 1'h0, 1'h0);
      w(2);
      @(posedge clock) dll_enable <= 1'h1;
   endtask
   task t_short;
      @(posedge clock) unc_seen <= 1'h0;
      ctl.drive(1'h0, 1'h1, 1'h0);
      ctl.drive(1'h1, 1'h0, 1'h0);
      w(3);
      `CHK("short_unc", 1'h1, unc_seen)
      w(14);
   endtask
   initial begin
      w(1);
      `CHK("rst_cmd_rx", 1'h1, cmd_rx_enable)
      `CHK("rst_async", 1'h0, async_mode)
      `CHK("rst_odt_rx", 1'h1, odt_rx_enable)
      repeat (5) @(posedge clock);
      nrst <= 1'h1;
      w(2);
      t_sync;
      t_pd;
      t_refresh;
      t_fast;
      t_short;
      tally_and_finish;
   end
   initial begin
      repeat (2000) @(posedge clock);
      error_cnt++;
      tally_and_finish;
   end
endmodule // testbench
